// *** rtl/bfs_pkg.sv ***
// ============================================================
// Branch fetch sequencer: shared constants and types
// ============================================================
package bfs_pkg;

  // ==========================================================
  // Widths, sizes and instruction lengths
  // ==========================================================
  localparam int          ADDR_W     = 32;
  localparam logic [1:0]  SIZE_HALF  = 2'h1;      // Halfword fetch.
  localparam logic [1:0]  SIZE_WORD  = 2'h2;      // Word fetch.
  localparam logic [31:0] LEN_WIDE   = 32'h4;     // 32-bit state length.
  localparam logic [31:0] LEN_NARROW = 32'h2;     // 16-bit state length.
  localparam logic        ST_WIDE    = 1'b0;      // State bit, 32-bit.
  localparam logic        ST_NARROW  = 1'b1;      // State bit, 16-bit.
  localparam logic [31:0] MASK_WIDE  = 32'hFFFF_FFFC;
  localparam logic [31:0] MASK_NARR  = 32'hFFFF_FFFE;
  localparam int          XSTATE_POS = 0;         // State bit in source.
  localparam logic [31:0] RESET_PC   = 32'h0000_0000;

  // ==========================================================
  // Sequencer states, Gray coded along the branch path
  // ==========================================================
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_C1  = 2'b01,
    ST_C2  = 2'b11,
    ST_C3  = 2'b10
  } bfs_state_t;

  // ==========================================================
  // Commands from the decode stage
  // ==========================================================
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,   // Plain instruction, prefetch continues.
    OP_B    = 3'h1,   // Branch.
    OP_BL   = 3'h2,   // Branch with link.
    OP_LBL1 = 3'h3,   // First half of the long branch with link.
    OP_LBL2 = 3'h4,   // Second half of the long branch with link.
    OP_BX   = 3'h5    // Branch and exchange.
  } bfs_op_t;

  typedef struct packed {
    bfs_op_t     op;
    logic [31:0] operand;
  } bfs_cmd_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  access_size;
    logic        read_not_write;
    logic        opcode_fetch_n;
    logic        translate_n;
    logic        state_bit;
    logic        memory_request_n;
    logic        sequential_cycle;
  } bfs_bus_t;

  typedef struct packed {
    logic        we;
    logic [31:0] data;
  } bfs_lr_t;

  // ==========================================================
  // Helpers used for every address step
  // ==========================================================
  function automatic logic [31:0] inst_len(input logic narrow);
    inst_len = narrow ? LEN_NARROW : LEN_WIDE;
  endfunction : inst_len

  function automatic logic [1:0] fetch_size(input logic narrow);
    fetch_size = narrow ? SIZE_HALF : SIZE_WORD;
  endfunction : fetch_size

  function automatic logic [31:0] align_addr(input logic [31:0] a,
                                             input logic        narrow);
    align_addr = a & (narrow ? MASK_NARR : MASK_WIDE);
  endfunction : align_addr

endpackage : bfs_pkg

// *** rtl/bfs_sequencer.sv ***
// What this block does
// - Request and sequential flags announce next cycle.
// - Address and attributes valid from the start of their cycle.
// - Prefetch advances by instruction length.
// - Fetch size two wide, one narrow.
// - Branch cycle one prefetches pc plus 2L.
// - Cycle two fetches target, writes return link.
// - Cycle three fetches target+L, link minus four.
// - Branch flags N,S,S; then fetch target+2L.
// - No single branch-with-link in narrow state.
// - Long link first half: link = pc+upper.
// - Long link second half: target, link, minus two.
// - Long link fetches pc+4,+6,target,target+2.
// - Exchange: three cycles, target and state extracted.
// - Exchange cycle two uses new width, state.
// - Exchange cycle three fetches target plus new width.
// - State bit 0 wide, 1 narrow, switches cycle two.
`timescale 1ns/100ps
`default_nettype none

module bfs_sequencer (
  input  wire logic          mclk,        // Core clock, 50 MHz.
  input  wire logic          rst,         // Synchronous reset, high.
  input  wire logic          ce,          // Clock enable, freezes all.
  input  wire logic          cmd_valid,   // Decode offers a command.
  input  wire bfs_pkg::bfs_cmd_t cmd,     // Command and operand.
  input  wire logic          privileged,  // Core in a privileged mode.
  output var  logic          cmd_ready,   // Sequencer takes a command.
  output var  bfs_pkg::bfs_bus_t bus,     // Memory bus cycle signals.
  output var  bfs_pkg::bfs_lr_t  lr_out,  // Link register write port.
  output var  logic          flush,       // Drop earlier prefetches.
  output var  logic          illegal      // Command not legal in state.
);
  import bfs_pkg::*;

  // ==========================================================
  // Registers
  // ==========================================================
  bfs_state_t  state_ff;
  logic [31:0] addr_ff;       // Address of the current bus cycle.
  logic        narrow_ff;     // Instruction state now on the bus.
  logic        new_narrow_ff; // State selected by the branch.
  logic [1:0]  size_ff;       // Fetch size now on the bus.
  logic [31:0] target_ff;     // Computed branch destination.
  logic [31:0] ret_ff;        // Return address, first cycle address.
  logic        link_ff;       // Branch writes the link register.
  logic [31:0] lbl_base_ff;   // Link value left by the first half.
  logic        seq_ff;
  logic        mreq_n_ff;
  logic        trans_n_ff;
  logic        lr_we_ff;
  logic [31:0] lr_data_ff;
  logic        flush_ff;
  logic        illegal_ff;
  logic        ready_ff;

  // ==========================================================
  // Command decode
  // ==========================================================
  logic        take;
  logic        legal;
  logic        is_branch;
  logic [31:0] nxt_fetch;
  logic [31:0] nxt_target;
  logic        nxt_new_narrow;
  bfs_state_t  nxt_state;

  // A command is taken only while the pipeline runs sequentially.
  assign take = ce & cmd_valid & ready_ff;

  // Legality of each command in the current instruction state.
  always_comb begin
    legal     = 1'b1;
    is_branch = 1'b0;
    case (cmd.op)
      OP_NONE: begin
        legal = 1'b1;
      end
      OP_B: begin
        is_branch = 1'b1;
      end
      OP_BL: begin
        legal     = ~narrow_ff;
        is_branch = ~narrow_ff;
      end
      OP_LBL1: begin
        legal = narrow_ff;
      end
      OP_LBL2: begin
        legal     = narrow_ff;
        is_branch = narrow_ff;
      end
      OP_BX: begin
        is_branch = 1'b1;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  assign nxt_fetch = addr_ff + inst_len(narrow_ff);

  // Destination and new state, formed in the cycle the branch is taken.
  always_comb begin
    nxt_target     = align_addr(nxt_fetch + cmd.operand, narrow_ff);
    nxt_new_narrow = narrow_ff;
    case (cmd.op)
      OP_LBL2: begin
        nxt_target = align_addr(lbl_base_ff + cmd.operand, ST_NARROW);
      end
      OP_BX: begin
        nxt_new_narrow = cmd.operand[XSTATE_POS];
        nxt_target     = align_addr(cmd.operand,
                                    cmd.operand[XSTATE_POS]);
      end
      default: begin
        nxt_target = align_addr(nxt_fetch + cmd.operand, narrow_ff);
      end
    endcase
  end

  // ==========================================================
  // Sequencer state
  // ==========================================================
  // three cycle branch
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (take && is_branch) begin
          nxt_state = ST_C1;
        end
      end
      ST_C1: begin
        nxt_state = ST_C2;
      end
      ST_C2: begin
        nxt_state = ST_C3;
      end
      ST_C3: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= ST_RUN;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Ready mirrors the running state so it stays a flip-flop.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ready_ff <= 1'b1;
    end else if (ce) begin
      ready_ff <= (nxt_state == ST_RUN);
    end
  end

  // ==========================================================
  // Branch bookkeeping, captured when the branch is taken
  // ==========================================================
  always_ff @(posedge mclk) begin
    if (rst) begin
      target_ff     <= RESET_PC;
      ret_ff        <= RESET_PC;
      link_ff       <= 1'b0;
      new_narrow_ff <= ST_WIDE;
    end else if (ce && take && is_branch) begin
      target_ff     <= nxt_target;
      ret_ff        <= nxt_fetch;
      link_ff       <= (cmd.op == OP_BL) || (cmd.op == OP_LBL2);
      new_narrow_ff <= nxt_new_narrow;
    end
  end

  // ==========================================================
  // Fetch address
  // ==========================================================
  // The address is registered at the start of its cycle, so it is
  // stable well ahead of the memory sampling point. The trade-off
  // is one cycle of latency from decode to the bus.
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_ff <= RESET_PC;
    end else if (ce) begin
      case (state_ff)
        ST_RUN: begin
          addr_ff <= nxt_fetch;
        end
        ST_C1: begin
          addr_ff <= target_ff;
        end
        ST_C2: begin
          addr_ff <= target_ff + inst_len(new_narrow_ff);
        end
        ST_C3: begin
          addr_ff <= nxt_fetch;
        end
        default: begin
          addr_ff <= nxt_fetch;
        end
      endcase
    end
  end

  // ==========================================================
  // Instruction state
  // ==========================================================
  // The fetch size has its own flop beside the state bit, so that the
  // bus sees a register and not a decode of one.
  // switch at cycle two
  always_ff @(posedge mclk) begin
    if (rst) begin
      narrow_ff <= ST_WIDE;
      size_ff   <= SIZE_WORD;
    end else if (ce && state_ff == ST_C1) begin
      narrow_ff <= new_narrow_ff;
      size_ff   <= fetch_size(new_narrow_ff);
    end
  end

  // ==========================================================
  // Cycle type flags, one cycle ahead
  // ==========================================================
  // announce next type
  always_ff @(posedge mclk) begin
    if (rst) begin
      seq_ff    <= 1'b1;
      mreq_n_ff <= 1'b0;
    end else if (ce) begin
      mreq_n_ff <= 1'b0;
      seq_ff    <= (nxt_state != ST_C1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      trans_n_ff <= 1'b0;
    end else if (ce) begin
      trans_n_ff <= privileged;
    end
  end

  // ==========================================================
  // Link register port
  // ==========================================================
  // The write port is a one-cycle pulse; data holds between writes.
  always_ff @(posedge mclk) begin
    if (rst) begin
      lr_we_ff    <= 1'b0;
      lr_data_ff  <= RESET_PC;
      lbl_base_ff <= RESET_PC;
    end else if (ce) begin
      lr_we_ff <= 1'b0;
      if (state_ff == ST_RUN && take && cmd.op == OP_LBL1 && legal) begin
        lr_we_ff    <= 1'b1;
        lr_data_ff  <= nxt_fetch + cmd.operand;
        lbl_base_ff <= nxt_fetch + cmd.operand;
      end else if (state_ff == ST_C1 && link_ff) begin
        lr_we_ff   <= 1'b1;
        lr_data_ff <= ret_ff;
      end else if (state_ff == ST_C2 && link_ff) begin
        lr_we_ff   <= 1'b1;
        lr_data_ff <= ret_ff - inst_len(narrow_ff);
      end
    end
  end

  // ==========================================================
  // Pipeline discard and illegal command report
  // ==========================================================
  // Flush marks the target fetch cycle; every fetch before it,
  // including the unavoidable cycle one prefetch, is stale.
  always_ff @(posedge mclk) begin
    if (rst) begin
      flush_ff <= 1'b0;
    end else if (ce) begin
      flush_ff <= (state_ff == ST_C1);
    end
  end

  // An illegal command is dropped; the prefetch stream carries on.
  always_ff @(posedge mclk) begin
    if (rst) begin
      illegal_ff <= 1'b0;
    end else if (ce) begin
      illegal_ff <= take & ~legal;
    end
  end

  // ==========================================================
  // Outputs, each straight from a flip-flop or a constant
  // ==========================================================
  assign cmd_ready = ready_ff;
  assign flush     = flush_ff;
  assign illegal   = illegal_ff;

  always_comb begin
    bus.addr             = addr_ff;
    bus.access_size      = size_ff;
    bus.read_not_write   = 1'b0;
    bus.opcode_fetch_n   = 1'b0;
    bus.translate_n      = trans_n_ff;
    bus.state_bit        = narrow_ff;
    bus.memory_request_n = mreq_n_ff;
    bus.sequential_cycle = seq_ff;
  end

  always_comb begin
    lr_out.we   = lr_we_ff;
    lr_out.data = lr_data_ff;
  end

endmodule : bfs_sequencer

`default_nettype wire

// *** testbench/bfs_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Memory side: answers each fetch with an address pattern
// ==========================================================
module bfs_mem_model
  import bfs_pkg::*;
(
  input  wire logic              mclk,    // Core clock.
  input  wire bfs_pkg::bfs_bus_t bus,     // Bus cycle from the core.
  output var  logic [31:0]       rd_data  // Fetched instruction word.
);
  // The word follows the low 16 address bits, so a stale answer within 64 KiB never looks valid.
  // address taken at cycle end
  always_ff @(posedge mclk) begin
    rd_data <= bus.memory_request_n ? ~rd_data
                                    : {bus.addr[15:0], ~bus.addr[15:0]};
  end
endmodule : bfs_mem_model
`default_nettype wire

// *** testbench/bfs_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Bus sequencing checks
// ==========================================================
module bfs_checker
  import bfs_pkg::*;
(
  input wire logic              mclk,        // Core clock.
  input wire logic              rst,         // Synchronous reset.
  input wire logic              ce,          // Clock enable.
  input wire logic              cmd_valid,   // Command offered.
  input wire bfs_pkg::bfs_cmd_t cmd,         // Command and operand.
  input wire logic              privileged,  // Privileged mode.
  input wire logic              cmd_ready,   // Command accepted.
  input wire bfs_pkg::bfs_bus_t bus,         // Bus cycle signals.
  input wire bfs_pkg::bfs_lr_t  lr_out,      // Link write port.
  input wire logic              flush,       // Prefetch discard.
  input wire logic              illegal      // Dropped command.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic take;
  logic br_take;
  // A refused branch must not count as a taken one.
  assign take    = ce && cmd_valid && cmd_ready;
  assign br_take = take && (cmd.op == OP_B || cmd.op == OP_BX ||
                   (cmd.op == OP_BL && !bus.state_bit) ||
                   (cmd.op == OP_LBL2 && bus.state_bit));
  chk_fetch_read: assert property (
    !bus.memory_request_n && !bus.read_not_write && !bus.opcode_fetch_n)
    else $error("bus cycle is not an opcode read");
  chk_size_match: assert property (
    bus.access_size == (bus.state_bit ? SIZE_HALF : SIZE_WORD))
    else $error("fetch size does not match state");
  chk_seq_step: assert property (
    take && cmd.op == OP_NONE |=> bus.addr == $past(bus.addr) +
    (bus.state_bit ? LEN_NARROW : LEN_WIDE))
    else $error("prefetch step wrong");
  chk_trans_follow: assert property (
    !$past(rst) && $past(ce) |-> bus.translate_n == $past(privileged))
    else $error("translate flag does not follow mode");
  chk_branch_flags: assert property (
    br_take && (cmd.op == OP_B || cmd.op == OP_BL) |=>
    !bus.sequential_cycle ##1 bus.sequential_cycle [*2])
    else $error("branch cycle types wrong");
  chk_first_prefetch: assert property (
    br_take && cmd.op != OP_LBL2 |=> bus.addr == $past(bus.addr) +
    (bus.state_bit ? LEN_NARROW : LEN_WIDE))
    else $error("first branch cycle address wrong");
  chk_ready_gap: assert property (
    br_take |=> !cmd_ready [*3] ##1 cmd_ready)
    else $error("branch length wrong");
  chk_flush_slot: assert property (
    br_take |=> !flush ##1 flush ##1 !flush)
    else $error("flush not in target cycle");
  chk_link_minus4: assert property (
    br_take && cmd.op == OP_BL |-> ##2 lr_out.we ##1
    (lr_out.we && lr_out.data == $past(lr_out.data) - 32'h4))
    else $error("link not reduced by four");
  chk_link_minus2: assert property (
    br_take && cmd.op == OP_LBL2 |-> ##2 lr_out.we ##1
    (lr_out.we && lr_out.data == $past(lr_out.data) - 32'h2))
    else $error("link not reduced by two");
  chk_bl_narrow: assert property (
    take && cmd.op == OP_BL && bus.state_bit |=> illegal && cmd_ready)
    else $error("narrow branch with link not refused");
  chk_xchg_state: assert property (
    br_take && cmd.op == OP_BX |=> $stable(bus.state_bit) ##1
    bus.state_bit == $past(cmd.operand[XSTATE_POS], 2))
    else $error("exchange state switch wrong");
  chk_xchg_refill: assert property (
    br_take && cmd.op == OP_BX |-> ##3 bus.addr == $past(bus.addr) +
    (bus.state_bit ? LEN_NARROW : LEN_WIDE))
    else $error("exchange refill address wrong");
  cov_link: cover property (br_take && cmd.op == OP_BL);
  cov_long: cover property (br_take && cmd.op == OP_LBL2);
  cov_xchg: cover property (br_take && cmd.op == OP_BX &&
                            cmd.operand[0] != bus.state_bit);
endmodule : bfs_checker
`default_nettype wire

// *** testbench/branch_fetch_sequencer_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module branch_fetch_sequencer_bench;
  import bfs_pkg::*;
  typedef struct packed {
    logic [31:0] a;   // Expected address.
    logic [31:0] d;   // Expected link data.
    logic [4:0]  fl;  // Seq, flush, link write, illegal, ready.
    logic        t;   // Expected state bit.
  } bfs_note_t;
  logic        mclk, rst, ce, cmd_valid, privileged;
  logic        cmd_ready, flush, illegal, nar;
  bfs_cmd_t    cmd;
  bfs_bus_t    bus;
  bfs_lr_t     lr_out;
  logic [31:0] pc, sv;
  bfs_note_t   q[$];
  bfs_note_t   wn;
  int          err_count, tests_run;

  bfs_sequencer u_bfs_sequencer (.mclk(mclk), .rst(rst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd(cmd), .privileged(privileged),
    .cmd_ready(cmd_ready), .bus(bus), .lr_out(lr_out),
    .flush(flush), .illegal(illegal));
  bfs_mem_model u_bfs_mem_model (.mclk(mclk), .bus(bus), .rd_data());

  // ==========================================================
  // Clock and helpers
  // ==========================================================
  always #10 mclk = ~mclk;

  function automatic logic [31:0] ln();
    ln = nar ? LEN_NARROW : LEN_WIDE;
  endfunction : ln

  // One cycle: drive a command, note what the next cycle must show.
  task automatic cyc(input bfs_op_t op, input logic [31:0] v, a,
                     input logic [4:0] fl, input logic [31:0] d);
    bfs_note_t n;
    cmd.op = op;
    cmd.operand = v;
    privileged = 1'($urandom);
    n = '{a: a, d: d, fl: fl, t: nar};
    @(posedge mclk);
    q.push_back(n);
    #1;
  endtask : cyc

  task automatic run(input int n);
    repeat (n) begin
      pc = pc + ln();
      cyc(OP_NONE, $urandom, pc, 5'h11, '0);
    end
  endtask : run

  task automatic bad(input bfs_op_t op);
    pc = pc + ln();
    cyc(op, $urandom, pc, 5'h13, '0);
  endtask : bad

  task automatic br(input logic link);
    logic [31:0] o, t;
    o = $urandom;
    t = (pc + ln() + o) & ~(ln() - 32'h1);
    cyc(link ? OP_BL : OP_B, o, pc + ln(), 5'h00, '0);
    cyc(OP_NONE, '0, t, {2'h3, link, 2'h0}, pc + ln());
    cyc(OP_NONE, '0, t + ln(), {2'h2, link, 2'h0}, pc);
    pc = t + ln();
    run(1);
  endtask : br

  task automatic lbl();
    logic [31:0] o1, o2, a, t;
    o1 = $urandom;
    o2 = $urandom;
    a = pc;
    t = (a + 32'h2 + o1 + o2) & ~32'h1;
    cyc(OP_LBL1, o1, a + 32'h2, 5'h15, a + 32'h2 + o1);
    cyc(OP_LBL2, o2, a + 32'h4, 5'h00, '0);
    cyc(OP_NONE, '0, t, 5'h1C, a + 32'h4);
    cyc(OP_NONE, '0, t + 32'h2, 5'h14, a + 32'h2);
    pc = t + 32'h2;
    run(1);
  endtask : lbl

  task automatic bx(input logic [31:0] v);
    logic [31:0] t;
    cyc(OP_BX, v, pc + ln(), 5'h00, '0);
    nar = v[0];
    t = v & ~(ln() - 32'h1);
    cyc(OP_NONE, '0, t, 5'h18, '0);
    cyc(OP_NONE, '0, t + ln(), 5'h10, '0);
    pc = t + ln();
    run(1);
  endtask : bx

  // ==========================================================
  // Comparison
  // ==========================================================
  task automatic cmp_bit(input string nm, input logic e, g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask : cmp_bit

  task automatic cmp_word(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask : cmp_word

  // Outputs settle well before mid-cycle, so sampling at +5 is safe.
  always @(posedge mclk) begin
    #5;
    if (q.size() > 0) begin
      wn = q.pop_front();
      cmp_word("addr", wn.a, bus.addr);
      cmp_bit("seq", wn.fl[4], bus.sequential_cycle);
      cmp_bit("state", wn.t, bus.state_bit);
      cmp_word("size", {30'h0, wn.t ? SIZE_HALF : SIZE_WORD},
               {30'h0, bus.access_size});
      cmp_bit("flush", wn.fl[3], flush);
      cmp_bit("lr_we", wn.fl[2], lr_out.we);
      if (wn.fl[2]) cmp_word("lr", wn.d, lr_out.data);
      cmp_bit("illegal", wn.fl[1], illegal);
      cmp_bit("ready", wn.fl[0], cmd_ready);
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // The sequence lasts about 65 cycles; allow far more.
  initial begin
    #(20 * 3000);
    err_count++;
    $display("watchdog expired");
    print_verdict();
  end

  // ==========================================================
  // Test sequence
  // ==========================================================
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    cmd_valid = 1'b1;
    privileged = 1'b0;
    cmd = '0;
    pc = '0;
    nar = 1'b0;
    err_count = 0;
    tests_run = 0;
    sv = $urandom(32'h8D335B7C);
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    run(3);
    ce = 1'b0;
    cyc(OP_B, $urandom, pc, 5'h11, '0);
    ce = 1'b1;
    run(1);
    $display("test prefetch done");
    br(1'b0);
    br(1'b1);
    bad(OP_LBL1);
    bad(OP_LBL2);
    bad(bfs_op_t'(3'h6));
    $display("test wide branch done");
    for (int k = 0; k < 4; k++) begin
      sv = $urandom;
      bx({sv[31:1], ~k[1]});
      if (k == 0) bad(OP_BL);
      if (k == 1) lbl();
      if (k == 1) lbl();
      if (k == 1) br(1'b0);
    end
    $display("test exchange done");
    repeat (2) @(posedge mclk);
    print_verdict();
  end
endmodule : branch_fetch_sequencer_bench

bind bfs_sequencer bfs_checker u_bfs_checker (.mclk(mclk), .rst(rst),
  .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd), .privileged(privileged),
  .cmd_ready(cmd_ready), .bus(bus), .lr_out(lr_out), .flush(flush),
  .illegal(illegal));
`default_nettype wire
